// *** hw/bfsp_pkg.sv ***
`default_nettype none

package bfsp_pkg;

    localparam int unsigned FLASH_AW = 15;
    localparam int unsigned CNT_W    = 32;
    localparam int unsigned CLK_PERIOD_NS = 40;

    // Flash geometry, word addresses
    localparam logic [FLASH_AW-1:0] FLASH_LAST_WORD  = 15'h7fff;
    localparam logic [FLASH_AW-1:0] APP_RESET_VECTOR = 15'h0000;
    localparam logic [FLASH_AW-1:0] HALT_SECT_START  = 15'h7000;

    // Boot section size per fuse code, in words
    localparam logic [FLASH_AW-1:0] BOOT_WORDS_FUSE_11 = 15'h0200;
    localparam logic [FLASH_AW-1:0] BOOT_WORDS_FUSE_10 = 15'h0400;
    localparam logic [FLASH_AW-1:0] BOOT_WORDS_FUSE_01 = 15'h0800;
    localparam logic [FLASH_AW-1:0] BOOT_WORDS_FUSE_00 = 15'h1000;

    // Lock bit pairs packed as {boot_high, boot_low, app_high, app_low}; 1 = unprogrammed
    localparam logic [3:0] LOCKS_ERASED = 4'h0f;
    localparam int unsigned APP_LOCK_LSB  = 0;
    localparam int unsigned BOOT_LOCK_LSB = 2;

    localparam logic FUSE_PROGRAMMED = 1'b0;

    typedef enum logic [3:0] {
        LOCK_MODE_1 = 4'b0001,
        LOCK_MODE_2 = 4'b0010,
        LOCK_MODE_3 = 4'b0100,
        LOCK_MODE_4 = 4'b1000
    } bfsp_lock_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b001,
        ST_BUSY_CONC = 3'b010,
        ST_BUSY_HALT = 3'b100
    } bfsp_state_t;

    typedef enum logic [2:0] {
        OP_PAGE_ERASE  = 3'h0,
        OP_PAGE_WRITE  = 3'h1,
        OP_PAGE_LOAD   = 3'h2,
        OP_LOCK_SET    = 3'h3,
        OP_READ_ENABLE = 3'h4
    } bfsp_op_t;

    typedef struct packed {
        logic                valid;
        bfsp_op_t            op;
        logic [FLASH_AW-1:0] addr;
        logic [3:0]          lock_data;
    } bfsp_spm_req_t;

    typedef struct packed {
        logic                valid;
        logic [FLASH_AW-1:0] addr;
    } bfsp_rd_req_t;

    typedef struct packed {
        logic                start;
        bfsp_op_t            op;
        logic [FLASH_AW-1:0] addr;
    } bfsp_flash_cmd_t;

endpackage

`default_nettype wire

// *** hw/bfsp_sync.sv ***
`default_nettype none

module bfsp_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule

`default_nettype wire

// *** hw/bfsp_boot_flash_protect.sv ***
// Overview of operation
// [R1] Programming starts only from boot-section code
// [R2] Boot code may program any flash page
// [R3] Size fuses split sections; pairs guard each
// [R4] Concurrent-section program keeps core running, halting-section reads
// [R5] Halting-section program stalls core throughout
// [R6] Any programming blocks concurrent-section code reads
// [R7] Software avoids concurrent-section access while programming
// [R8] Busy flag high while concurrent section blocked
// [R9] Software clears busy flag before concurrent reads
// [R10] Boot section always inside halting section
// [R11] Software only programs lock bits; erase clears
// [R12] General lock modes ignored by program access
// [R13] Lock pair bits decode to modes one-four
// [R14] App modes 2,3 forbid app page programming
// [R15] App modes 3,4 forbid boot loads from app
// [R16] App modes 3,4 mask interrupts in app; the code masks them only while vectors_in_boot is set
// [R17] Boot modes 2,3 forbid boot page programming
// [R18] Boot modes 3,4 forbid app loads from boot
// [R19] Boot modes 3,4 mask interrupts in boot; the code masks them only while vectors_in_boot is clear
// [R20] Programmed reset fuse starts at boot section
// [R21] Fuses cannot be changed by the core
// [R22] Unprogrammed reset fuse selects address zero
// [R23] Read-enable write after finish clears busy flag
// [R24] Forbidden programming is ignored, no busy period
`default_nettype none

module bfsp_boot_flash_protect #(
    parameter int unsigned PROG_TIME_NS = 4000000,
    parameter int unsigned PROG_CYCLES  = (PROG_TIME_NS + bfsp_pkg::CLK_PERIOD_NS - 1)
                                          / bfsp_pkg::CLK_PERIOD_NS
) (
    input  wire logic                             clk,
    input  wire logic                             reset,
    input  wire logic [1:0]                       boot_size_fuses,
    input  wire logic                             boot_reset_vector_fuse,
    input  wire logic [3:0]                       lock_bits_stored,
    input  wire logic                             chip_erase,
    input  wire logic [bfsp_pkg::FLASH_AW-1:0]    exec_addr,
    input  wire logic                             vectors_in_boot,
    input  wire bfsp_pkg::bfsp_spm_req_t          spm_req,
    input  wire bfsp_pkg::bfsp_rd_req_t           load_req,
    input  wire bfsp_pkg::bfsp_rd_req_t           fetch_req,
    output logic                                  concurrent_section_busy_flag,
    output logic                                  cpu_stall,
    output bfsp_pkg::bfsp_flash_cmd_t             flash_cmd,
    output logic                                  spm_refused,
    output logic                                  load_grant,
    output logic                                  load_deny,
    output logic                                  fetch_fault,
    output logic                                  irq_enable,
    output logic [bfsp_pkg::FLASH_AW-1:0]         reset_vector,
    output logic [3:0]                            lock_bits,
    output logic                                  lock_write
);

    localparam int unsigned AW = bfsp_pkg::FLASH_AW;
    // Edges after reset until the pin synchroniser shows real pin levels
    localparam logic [1:0]  SYNC_FLUSH = 2'h2;

    typedef struct packed {
        bfsp_pkg::bfsp_state_t     state;
        logic [bfsp_pkg::CNT_W-1:0] cnt;
        logic                      busy;
        logic                      stall;
        bfsp_pkg::bfsp_flash_cmd_t cmd;
        logic                      refused;
        logic                      ld_grant;
        logic                      ld_deny;
        logic                      f_fault;
        logic                      irq_en;
        logic [AW-1:0]             rst_vec;
        logic [3:0]                locks;
        logic                      locks_loaded;
        logic [1:0]                settle;
        logic                      lk_write;
    } bfsp_regs_t;

    bfsp_regs_t r_ff;
    bfsp_regs_t nxt_r;

    // Fuses, stored locks and chip erase come from the programming pins
    logic [1:0]    size_s;
    logic          rstfuse_s;
    logic [3:0]    locks_s;
    logic          erase_s;

    bfsp_sync #(
        .WIDTH (8)
    ) u_pin_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in ({boot_size_fuses, boot_reset_vector_fuse, lock_bits_stored, chip_erase}),
        .sync_out ({size_s, rstfuse_s, locks_s, erase_s})
    );

    function automatic bfsp_pkg::bfsp_lock_mode_t lock_mode(input logic [1:0] pair);
        unique case (pair)
            2'b11:   lock_mode = bfsp_pkg::LOCK_MODE_1; // R13
            2'b10:   lock_mode = bfsp_pkg::LOCK_MODE_2; // R13
            2'b00:   lock_mode = bfsp_pkg::LOCK_MODE_3; // R13
            default: lock_mode = bfsp_pkg::LOCK_MODE_4; // R13
        endcase
    endfunction

    function automatic logic write_locked(input bfsp_pkg::bfsp_lock_mode_t m);
        write_locked = (m == bfsp_pkg::LOCK_MODE_2) || (m == bfsp_pkg::LOCK_MODE_3);
    endfunction

    function automatic logic read_locked(input bfsp_pkg::bfsp_lock_mode_t m);
        read_locked = (m == bfsp_pkg::LOCK_MODE_3) || (m == bfsp_pkg::LOCK_MODE_4);
    endfunction

    logic [AW-1:0]             boot_words;
    logic [AW-1:0]             boot_start;
    bfsp_pkg::bfsp_lock_mode_t app_mode;
    bfsp_pkg::bfsp_lock_mode_t boot_mode;
    logic                      exec_boot;
    logic                      tgt_boot;
    logic                      tgt_halt;
    logic                      ld_boot;
    logic                      spm_ok;
    logic                      prog_op;

    always_comb begin
        unique case (size_s)
            2'b11:   boot_words = bfsp_pkg::BOOT_WORDS_FUSE_11; // R3
            2'b10:   boot_words = bfsp_pkg::BOOT_WORDS_FUSE_10; // R3
            2'b01:   boot_words = bfsp_pkg::BOOT_WORDS_FUSE_01; // R3
            default: boot_words = bfsp_pkg::BOOT_WORDS_FUSE_00; // R3
        endcase
        // A size table entry larger than the halting section is clipped to it
        if (boot_words > (bfsp_pkg::FLASH_LAST_WORD - bfsp_pkg::HALT_SECT_START + 15'h0001)) begin
            boot_start = bfsp_pkg::HALT_SECT_START; // R10
        end else begin
            boot_start = bfsp_pkg::FLASH_LAST_WORD - boot_words + 15'h0001; // R3
        end
    end

    // The general lock modes are not inputs here, so they cannot gate access
    assign app_mode  = lock_mode(r_ff.locks[bfsp_pkg::APP_LOCK_LSB +: 2]); // R3 R12
    assign boot_mode = lock_mode(r_ff.locks[bfsp_pkg::BOOT_LOCK_LSB +: 2]); // R3 R12
    assign exec_boot = exec_addr >= boot_start;
    assign tgt_boot  = spm_req.addr >= boot_start;
    assign tgt_halt  = spm_req.addr >= bfsp_pkg::HALT_SECT_START;
    assign ld_boot   = load_req.addr >= boot_start;
    assign prog_op   = (spm_req.op == bfsp_pkg::OP_PAGE_ERASE)
                    || (spm_req.op == bfsp_pkg::OP_PAGE_WRITE);

    always_comb begin
        spm_ok = exec_boot; // R1 R2
        if (prog_op && tgt_boot && write_locked(boot_mode)) begin
            spm_ok = 1'b0; // R17
        end
        if (prog_op && !tgt_boot && write_locked(app_mode)) begin
            spm_ok = 1'b0; // R14
        end
    end

    always_comb begin
        nxt_r           = r_ff;
        nxt_r.cmd.start = 1'b0;
        nxt_r.refused   = 1'b0;
        nxt_r.ld_grant  = 1'b0;
        nxt_r.ld_deny   = 1'b0;
        nxt_r.lk_write  = 1'b0;

        // The synchroniser restarts at zero, which would read as all locks programmed
        if (r_ff.settle != SYNC_FLUSH) begin
            nxt_r.settle = r_ff.settle + 2'h1;
        end else if (!r_ff.locks_loaded) begin
            nxt_r.locks        = locks_s;
            nxt_r.locks_loaded = 1'b1;
        end

        unique case (r_ff.state)
            bfsp_pkg::ST_IDLE: begin
                if (spm_req.valid && r_ff.locks_loaded) begin
                    if (!spm_ok) begin
                        nxt_r.refused = 1'b1; // R1 R24
                    end else if (prog_op) begin
                        nxt_r.cmd.start = 1'b1;
                        nxt_r.cmd.op    = spm_req.op;
                        nxt_r.cmd.addr  = spm_req.addr;
                        nxt_r.cnt       = '0;
                        nxt_r.busy      = 1'b1; // R6 R8
                        if (tgt_halt) begin
                            nxt_r.state = bfsp_pkg::ST_BUSY_HALT; // R5
                            nxt_r.stall = 1'b1; // R5
                        end else begin
                            nxt_r.state = bfsp_pkg::ST_BUSY_CONC; // R4
                        end
                    end else if (spm_req.op == bfsp_pkg::OP_LOCK_SET) begin
                        // Software can only program bits towards zero
                        nxt_r.locks    = r_ff.locks & spm_req.lock_data; // R11
                        nxt_r.lk_write = 1'b1;
                    end else if (spm_req.op == bfsp_pkg::OP_READ_ENABLE) begin
                        nxt_r.busy = 1'b0; // R23
                    end
                end
            end
            bfsp_pkg::ST_BUSY_CONC,
            bfsp_pkg::ST_BUSY_HALT: begin
                // Requests during a busy period are refused, the array is occupied
                if (spm_req.valid) begin
                    nxt_r.refused = 1'b1;
                end
                nxt_r.cnt = r_ff.cnt + 32'h0000_0001;
                if (r_ff.cnt >= PROG_CYCLES[bfsp_pkg::CNT_W-1:0] - 32'h0000_0001) begin
                    nxt_r.state = bfsp_pkg::ST_IDLE;
                    nxt_r.stall = 1'b0;
                end
            end
            default: begin
                nxt_r.state = bfsp_pkg::ST_IDLE;
                nxt_r.stall = 1'b0;
            end
        endcase

        // Only an erase brings locks back; it wins over any software change
        if (erase_s) begin
            nxt_r.locks        = bfsp_pkg::LOCKS_ERASED; // R11
            nxt_r.locks_loaded = 1'b1;
        end

        if (load_req.valid) begin
            if ((r_ff.busy && !(load_req.addr >= bfsp_pkg::HALT_SECT_START))
                || (exec_boot && !ld_boot && read_locked(app_mode))
                || (!exec_boot && ld_boot && read_locked(boot_mode))) begin
                nxt_r.ld_deny  = 1'b1; // R6 R15 R18
            end else begin
                nxt_r.ld_grant = 1'b1;
            end
        end
        // A fetch into a blocked section is flagged; software must not do it
        nxt_r.f_fault = fetch_req.valid && r_ff.busy
                     && !(fetch_req.addr >= bfsp_pkg::HALT_SECT_START); // R6 R7 R9

        nxt_r.irq_en = !((vectors_in_boot && !exec_boot && read_locked(app_mode)) // R16
                      || (!vectors_in_boot && exec_boot && read_locked(boot_mode))); // R19

        // Fuses only arrive through the synchroniser; nothing here writes them
        if (r_ff.settle == SYNC_FLUSH) begin
            nxt_r.rst_vec = (rstfuse_s == bfsp_pkg::FUSE_PROGRAMMED)
                          ? boot_start : bfsp_pkg::APP_RESET_VECTOR; // R20 R21 R22
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r_ff              <= '0;
            r_ff.state        <= bfsp_pkg::ST_IDLE;
            r_ff.locks        <= bfsp_pkg::LOCKS_ERASED;
            r_ff.irq_en       <= 1'b1;
            r_ff.rst_vec      <= bfsp_pkg::APP_RESET_VECTOR;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign concurrent_section_busy_flag = r_ff.busy;
    assign cpu_stall    = r_ff.stall;
    assign flash_cmd    = r_ff.cmd;
    assign spm_refused  = r_ff.refused;
    assign load_grant   = r_ff.ld_grant;
    assign load_deny    = r_ff.ld_deny;
    assign fetch_fault  = r_ff.f_fault;
    assign irq_enable   = r_ff.irq_en;
    assign reset_vector = r_ff.rst_vec;
    assign lock_bits    = r_ff.locks;
    assign lock_write   = r_ff.lk_write;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_refuse_app_exec: assert property ( // R1
        spm_req.valid && r_ff.state == bfsp_pkg::ST_IDLE && !exec_boot && r_ff.locks_loaded
        |=> spm_refused && !flash_cmd.start)
        else $error("programming accepted from application code");

    a_halt_stall_span: assert property ( // R5
        flash_cmd.start && r_ff.state == bfsp_pkg::ST_BUSY_HALT
        |-> cpu_stall throughout (r_ff.state == bfsp_pkg::ST_BUSY_HALT)[*2])
        else $error("core not stalled during halting-section programming");

    a_conc_no_stall: assert property ( // R4
        r_ff.state == bfsp_pkg::ST_BUSY_CONC |-> !cpu_stall && concurrent_section_busy_flag)
        else $error("core stalled during concurrent-section programming");

    a_busy_on_start: assert property ( // R8
        flash_cmd.start |-> concurrent_section_busy_flag)
        else $error("busy flag low at programming start");

    a_busy_hold: assert property ( // R23
        $fell(concurrent_section_busy_flag)
        |-> $past(spm_req.valid) && $past(spm_req.op) == bfsp_pkg::OP_READ_ENABLE
            && $past(r_ff.state) == bfsp_pkg::ST_IDLE)
        else $error("busy flag cleared without read enable");

    a_app_write_lock: assert property ( // R14
        spm_req.valid && prog_op && !tgt_boot && write_locked(app_mode)
        |=> !flash_cmd.start)
        else $error("locked application page programmed");

    a_boot_write_lock: assert property ( // R17
        spm_req.valid && prog_op && tgt_boot && write_locked(boot_mode)
        |=> !flash_cmd.start)
        else $error("locked boot page programmed");

    a_app_read_lock: assert property ( // R15
        load_req.valid && exec_boot && !ld_boot && read_locked(app_mode) |=> load_deny)
        else $error("boot load of locked application section granted");

    a_boot_read_lock: assert property ( // R18
        load_req.valid && !exec_boot && ld_boot && read_locked(boot_mode) |=> load_deny)
        else $error("application load of locked boot section granted");

    a_lock_only_prog: assert property ( // R11
        !erase_s && $past(r_ff.locks_loaded) |=> (lock_bits & ~$past(lock_bits)) == 4'h0)
        else $error("lock bit returned to unprogrammed without erase");

    a_reset_vector: assert property ( // R20
        r_ff.settle == SYNC_FLUSH && rstfuse_s == bfsp_pkg::FUSE_PROGRAMMED
        |=> reset_vector == $past(boot_start))
        else $error("reset vector not at boot section");

    a_boot_in_halt: assert property ( // R10
        boot_start >= bfsp_pkg::HALT_SECT_START)
        else $error("boot section outside halting section");

    c_halt_prog: cover property (flash_cmd.start && r_ff.state == bfsp_pkg::ST_BUSY_HALT);
    c_conc_prog: cover property (flash_cmd.start && r_ff.state == bfsp_pkg::ST_BUSY_CONC);
    c_busy_clear: cover property ($fell(concurrent_section_busy_flag));
    c_lock_refuse: cover property (spm_refused && exec_boot);

endmodule

`default_nettype wire

// *** verification/bfsp_core_model.sv ***
`default_nettype none

module bfsp_core_model (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          busy,
    input  wire logic                          stall,
    input  wire logic                          cmd_valid,
    input  wire logic [1:0]                    cmd_kind,
    input  wire bfsp_pkg::bfsp_op_t            cmd_op,
    input  wire logic [bfsp_pkg::FLASH_AW-1:0] cmd_addr,
    input  wire logic [3:0]                    cmd_lock,
    input  wire logic [bfsp_pkg::FLASH_AW-1:0] cmd_exec,
    input  wire logic                          rogue,
    output bfsp_pkg::bfsp_spm_req_t            spm_req,
    output bfsp_pkg::bfsp_rd_req_t             load_req,
    output bfsp_pkg::bfsp_rd_req_t             fetch_req,
    output logic [bfsp_pkg::FLASH_AW-1:0]      exec_addr
);
    timeunit 1ns;
    timeprecision 1ns;

    logic                          go;
    logic                          safe;
    logic [bfsp_pkg::FLASH_AW-1:0] a;

    // A stalled core issues nothing at all
    assign go = cmd_valid && !stall;
    // Idle address lines toggle so a design never leans on a stale value
    assign a = go ? cmd_addr : ~cmd_addr;
    // Unless rogue is set, loads and fetches stay clear of the concurrent section until its busy flag is cleared
    assign safe = rogue || !busy || (cmd_addr >= bfsp_pkg::HALT_SECT_START);

    always_ff @(posedge clk) begin
        exec_addr <= cmd_exec;
        if (reset) begin
            spm_req   <= '0;
            load_req  <= '0;
            fetch_req <= '0;
        end else begin
            spm_req   <= {go && cmd_kind == 2'h0, cmd_op, a, cmd_lock};
            load_req  <= {go && cmd_kind == 2'h1 && safe, a};
            fetch_req <= {go && cmd_kind == 2'h2 && safe, a};
        end
    end
endmodule

`default_nettype wire

// *** verification/boot_flash_section_protection_tb.sv ***
`default_nettype none

module boot_flash_section_protection_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int PC = 8;

    logic                      clk, reset, chip_erase, vib, fuse_rst, rogue, cmd_valid;
    logic [1:0]                size_f, cmd_kind;
    logic [3:0]                stored, cmd_lock, lock_bits;
    logic [14:0]               cmd_addr, exec_q, exec_addr, reset_vector, boot_lo, app_pg, halt_pg;
    bfsp_pkg::bfsp_op_t        cmd_op;
    bfsp_pkg::bfsp_spm_req_t   spm_req;
    bfsp_pkg::bfsp_rd_req_t    load_req, fetch_req;
    bfsp_pkg::bfsp_flash_cmd_t flash_cmd;
    logic                      busy, stall, refused, grant, deny, fault, irq_en, lock_write;
    logic [2:0]                ev;
    logic [2:0]                expq[$];
    int                        mismatches, n_compared;
    integer                    seed;

    bfsp_boot_flash_protect #(.PROG_CYCLES(PC)) dut (
        .clk(clk), .reset(reset), .boot_size_fuses(size_f), .boot_reset_vector_fuse(fuse_rst),
        .lock_bits_stored(stored), .chip_erase(chip_erase), .exec_addr(exec_addr),
        .vectors_in_boot(vib), .spm_req(spm_req), .load_req(load_req), .fetch_req(fetch_req),
        .concurrent_section_busy_flag(busy), .cpu_stall(stall), .flash_cmd(flash_cmd),
        .spm_refused(refused), .load_grant(grant), .load_deny(deny), .fetch_fault(fault),
        .irq_enable(irq_en), .reset_vector(reset_vector), .lock_bits(lock_bits),
        .lock_write(lock_write)
    );

    bfsp_core_model u_core (
        .clk(clk), .reset(reset), .busy(busy), .stall(stall), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_lock(cmd_lock),
        .cmd_exec(exec_q), .rogue(rogue), .spm_req(spm_req), .load_req(load_req),
        .fetch_req(fetch_req), .exec_addr(exec_addr)
    );

    // Codes: 1 start, 2 refused, 3 lock write, 4 grant, 5 deny, 6 fetch fault
    assign ev = (flash_cmd.start && flash_cmd.op inside {bfsp_pkg::OP_PAGE_ERASE,
                 bfsp_pkg::OP_PAGE_WRITE}) ? 3'h1 : refused ? 3'h2 : lock_write ? 3'h3 :
                grant ? 3'h4 : deny ? 3'h5 : fault ? 3'h6 : 3'h0;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic issue(input logic [1:0] k, input bfsp_pkg::bfsp_op_t op,
                         input logic [14:0] a, input logic [3:0] ld, input logic [2:0] exp);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_kind  <= k;
        cmd_op    <= op;
        cmd_addr  <= a;
        cmd_lock  <= ld;
        if (exp != 3'h0) expq.push_back(exp);
        @(posedge clk);
        cmd_valid <= 1'b0;
        cyc(3);
    endtask

    function automatic logic [14:0] boot_start(input logic [1:0] f);
        case (f)
            2'b11: boot_start = bfsp_pkg::BOOT_WORDS_FUSE_11;
            2'b10: boot_start = bfsp_pkg::BOOT_WORDS_FUSE_10;
            2'b01: boot_start = bfsp_pkg::BOOT_WORDS_FUSE_01;
            default: boot_start = bfsp_pkg::BOOT_WORDS_FUSE_00;
        endcase
        boot_start = bfsp_pkg::FLASH_LAST_WORD - boot_start + 15'h0001;
    endfunction

    // Answers are matched in issue order; a stray answer shows up here, a missing one at the final answers left check
    always @(negedge clk) begin
        if (reset === 1'b0 && ev !== 3'h0) begin
            if (expq.size() == 0) chk("unexpected answer", {29'h0, ev}, 32'h0);
            else chk("answer", {29'h0, ev}, {29'h0, expq.pop_front()});
        end
    end

    task automatic clear_busy();
        int i;
        i = 0;
        while (stall !== 1'b0) begin
            @(negedge clk);
            i++;
            if (i > 4 * PC) begin
                mismatches++;
                stop_test();
            end
        end
        chk("busy after finish", busy, 1);
        issue(2'h0, bfsp_pkg::OP_READ_ENABLE, 15'h0000, 4'h0, 3'h0);
        chk("busy cleared", busy, 0);
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end

    initial begin
        seed = 32'hb1ac_2a0b;
        {reset, chip_erase, vib, fuse_rst, rogue, cmd_valid} = 6'b101100;
        size_f = 2'b11;
        stored = bfsp_pkg::LOCKS_ERASED;
        {cmd_kind, cmd_lock, cmd_addr} = '0;
        cmd_op = bfsp_pkg::OP_PAGE_LOAD;
        boot_lo = boot_start(2'b11);
        exec_q = boot_lo;
        app_pg = 15'({$random(seed)} % 32'h0000_7000);
        halt_pg = 15'h7000 + 15'({$random(seed)} % 32'h0000_0e00);
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        cyc(4);
        chk("busy", busy, 0);
        chk("stall", stall, 0);
        chk("irq enable", irq_en, 1);
        chk("reset vector", reset_vector, bfsp_pkg::APP_RESET_VECTOR);
        chk("locks", lock_bits, bfsp_pkg::LOCKS_ERASED);
        $display("test reset_values done");

        exec_q <= app_pg;
        issue(2'h0, bfsp_pkg::OP_PAGE_ERASE, halt_pg, 4'h0, 3'h2);
        chk("busy", busy, 0);
        exec_q <= boot_lo;
        issue(2'h0, bfsp_pkg::OP_PAGE_ERASE, app_pg, 4'h0, 3'h1);
        chk("busy", busy, 1);
        chk("stall", stall, 0);
        // Lands while the concurrent erase still runs, so it must be refused
        issue(2'h0, bfsp_pkg::OP_PAGE_WRITE, halt_pg, 4'h0, 3'h2);
        issue(2'h1, bfsp_pkg::OP_PAGE_LOAD, halt_pg, 4'h0, 3'h4);
        rogue <= 1'b1;
        issue(2'h2, bfsp_pkg::OP_PAGE_LOAD, app_pg, 4'h0, 3'h6);
        issue(2'h1, bfsp_pkg::OP_PAGE_LOAD, app_pg, 4'h0, 3'h5);
        rogue <= 1'b0;
        cyc(2 * PC);
        clear_busy();
        $display("test concurrent_program done");

        issue(2'h0, bfsp_pkg::OP_PAGE_ERASE, boot_lo, 4'h0, 3'h1);
        chk("stall", stall, 1);
        chk("busy", busy, 1);
        chk("cmd addr", flash_cmd.addr, boot_lo);
        chk("cmd op", flash_cmd.op, bfsp_pkg::OP_PAGE_ERASE);
        clear_busy();
        $display("test halting_program done");

        issue(2'h0, bfsp_pkg::OP_LOCK_SET, 15'h0000, 4'b1101, 3'h3);
        chk("locks", lock_bits, 4'b1101);
        issue(2'h0, bfsp_pkg::OP_PAGE_WRITE, app_pg, 4'h0, 3'h1);
        cyc(PC);
        clear_busy();
        issue(2'h1, bfsp_pkg::OP_PAGE_LOAD, app_pg, 4'h0, 3'h5);
        exec_q <= app_pg;
        cyc(3);
        chk("irq enable", irq_en, 0);
        exec_q <= boot_lo;
        chip_erase <= 1'b1;
        cyc(4);
        chip_erase <= 1'b0;
        cyc(4);
        chk("locks", lock_bits, bfsp_pkg::LOCKS_ERASED);
        issue(2'h0, bfsp_pkg::OP_LOCK_SET, 15'h0000, 4'b1110, 3'h3);
        issue(2'h0, bfsp_pkg::OP_PAGE_ERASE, app_pg, 4'h0, 3'h2);
        chk("busy", busy, 0);
        issue(2'h1, bfsp_pkg::OP_PAGE_LOAD, app_pg, 4'h0, 3'h4);
        issue(2'h0, bfsp_pkg::OP_LOCK_SET, 15'h0000, 4'b1011, 3'h3);
        issue(2'h0, bfsp_pkg::OP_PAGE_ERASE, boot_lo, 4'h0, 3'h2);
        issue(2'h0, bfsp_pkg::OP_LOCK_SET, 15'h0000, 4'b0110, 3'h3);
        chk("locks", lock_bits, 4'b0010);
        exec_q <= app_pg;
        issue(2'h1, bfsp_pkg::OP_PAGE_LOAD, boot_lo, 4'h0, 3'h5);
        vib <= 1'b0;
        cyc(3);
        chk("irq enable", irq_en, 1);
        exec_q <= boot_lo;
        cyc(3);
        chk("irq enable", irq_en, 0);
        $display("test lock_modes done");

        for (int i = 0; i < 4; i++) begin
            fuse_rst <= bfsp_pkg::FUSE_PROGRAMMED;
            size_f <= 2'(i);
            reset <= 1'b1;
            cyc(10);
            reset <= 1'b0;
            cyc(4);
            chk("boot reset vector", reset_vector, boot_start(2'(i)));
        end
        $display("test reset_vector done");
        cyc(5);
        chk("answers left", expq.size(), 0);
        stop_test();
    end
endmodule

`default_nettype wire
